// ===== design/pdc_pkg.sv
// Package with register map, field layout and shared types of the channel
package pdc_pkg;

	// ==========================================================
	// Register byte offsets
	// ==========================================================
	localparam logic [5:0] PDC_RX_PTR_OFS   = 6'h00;
	localparam logic [5:0] PDC_RX_CNT_OFS   = 6'h04;
	localparam logic [5:0] PDC_TX_PTR_OFS   = 6'h08;
	localparam logic [5:0] PDC_TX_CNT_OFS   = 6'h0c;
	localparam logic [5:0] PDC_RX_NPTR_OFS  = 6'h10;
	localparam logic [5:0] PDC_RX_NCNT_OFS  = 6'h14;
	localparam logic [5:0] PDC_TX_NPTR_OFS  = 6'h18;
	localparam logic [5:0] PDC_TX_NCNT_OFS  = 6'h1c;
	localparam logic [5:0] PDC_CTRL_OFS     = 6'h20;
	localparam logic [5:0] PDC_STAT_OFS     = 6'h24;
	localparam logic [5:0] PDC_FLAG_OFS     = 6'h28;
	localparam logic [5:0] PDC_MODE_OFS     = 6'h2c;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int PDC_CTRL_RXON_BIT  = 0;
	localparam int PDC_CTRL_RXOFF_BIT = 1;
	localparam int PDC_CTRL_TXON_BIT  = 8;
	localparam int PDC_CTRL_TXOFF_BIT = 9;
	localparam int PDC_STAT_RX_TRIGGER_ENABLE_BIT  = 0;
	localparam int PDC_STAT_TX_TRIGGER_ENABLE_BIT  = 8;
	localparam int PDC_FLAG_RECEIVE_SEGMENT_DONE_BIT = 0;
	localparam int PDC_FLAG_TRANSMIT_SEGMENT_DONE_BIT = 1;
	localparam int PDC_FLAG_RXBF_BIT  = 2;
	localparam int PDC_FLAG_TXBE_BIT  = 3;
	localparam int PDC_MODE_HALF_BIT  = 0;
	localparam int PDC_MODE_DIRTX_BIT = 1;
	localparam int PDC_MODE_SIZE_LSB  = 4;

	// ==========================================================
	// Widths, reset values and encodings
	// ==========================================================
	localparam int PDC_PTR_W = 32;
	localparam int PDC_CNT_W = 16;
	localparam logic [31:0] PDC_ZERO32 = 32'h0000_0000;
	localparam logic [15:0] PDC_ZERO16 = 16'h0000;
	localparam logic [15:0] PDC_ONE16  = 16'h0001;
	localparam logic [1:0] PDC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PDC_RESP_SLVERR = 2'h2;

	// Item size: pointer steps 1, 2 or 4 bytes
	typedef enum logic [1:0]
	{
		PDC_SZ_BYTE = 2'h0,
		PDC_SZ_HALF = 2'h1,
		PDC_SZ_WORD = 2'h2
	} pdc_size_e;

	// One pointer/counter set
	typedef struct packed
	{
		logic [31:0] ptr;
		logic [15:0] cnt;
	} pdc_set_s;

	// Memory-side request of the bus matrix port
	typedef struct packed
	{
		logic        req;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		pdc_size_e   size;
	} pdc_mreq_s;

endpackage

// ===== design/pdc_dir.sv
// One direction of the channel: current/next sets, reload and end flags
module pdc_dir
	import pdc_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      sys_rst,
	input  wire logic      enable,
	input  wire logic      wrCur,
	input  wire logic      wrNext,
	input  wire logic      selPtr,
	input  wire logic [31:0] wdata,
	input  wire logic      step,
	input  wire pdc_pkg::pdc_size_e size,
	output pdc_pkg::pdc_set_s curSet,
	output pdc_pkg::pdc_set_s nextSet,
	output logic           active,
	output logic           endFlag,
	output logic           bufFlag
);
	import pdc_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed
	{
		pdc_set_s cur;      // Current set
		pdc_set_s nxt;      // Next set
		logic     endF;     // Segment done
		logic     bufF;     // Both sets drained
	} pdc_dir_s;

	pdc_dir_s  st_q;            // Registered state
	pdc_dir_s  st_d;            // Next state
	logic [31:0] stepBytes;     // Pointer increment
	logic        hitZero;       // Last item of the current set moves now

	// A flag set by the last item beats a clear written in the same cycle
	assign hitZero = step && enable && (st_q.cur.cnt == PDC_ONE16);

	// Step size by item width
	always_comb
	begin
		case (size)
			PDC_SZ_BYTE: stepBytes = 32'h0000_0001;
			PDC_SZ_HALF: stepBytes = 32'h0000_0002;
			default:     stepBytes = 32'h0000_0004;
		endcase
	end

	// Next-state logic; a software write in the same cycle as a step wins
	// for the written field so a rewritten pointer is used from then on
	always_comb
	begin
		st_d = st_q;
		if (step && enable && (st_q.cur.cnt != PDC_ZERO16))
		begin
			st_d.cur.ptr = st_q.cur.ptr + stepBytes;
			st_d.cur.cnt = st_q.cur.cnt - PDC_ONE16;
			if (st_q.cur.cnt == PDC_ONE16)
			begin
				st_d.endF = 1'b1;
				if (st_q.nxt.cnt != PDC_ZERO16)
				begin
					st_d.cur = st_q.nxt;
					st_d.nxt = {PDC_ZERO32, PDC_ZERO16};
				end
				else
				begin
					st_d.bufF = 1'b1;
				end
			end
		end
		// Software writes to the sets
		if (wrCur)
		begin
			if (selPtr)
				st_d.cur.ptr = wdata;
			else
			begin
				st_d.cur.cnt = wdata[15:0];
				if ((wdata[15:0] != PDC_ZERO16) && !hitZero)
				begin
					st_d.endF = 1'b0;
					st_d.bufF = 1'b0;
				end
			end
		end
		if (wrNext)
		begin
			if (selPtr)
				st_d.nxt.ptr = wdata;
			else
			begin
				st_d.nxt.cnt = wdata[15:0];
				if ((wdata[15:0] != PDC_ZERO16) && !hitZero)
				begin
					st_d.endF = 1'b0;
					st_d.bufF = 1'b0;
				end
			end
		end
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign curSet  = st_q.cur;
	assign nextSet = st_q.nxt;
	// Zero counter halts the direction
	assign active  = enable && (st_q.cur.cnt != PDC_ZERO16);
	assign endFlag = st_q.endF;
	assign bufFlag = st_q.bufF;

endmodule

// ===== design/pdc_channel.sv
// Peripheral DMA channel top: AXI4-Lite registers, transfer sequencer
// Notes on behaviour
// - Each direction has current and next sets
// - Four pointers, four counters for duplex peripherals
// - Half duplex: program only one direction
// - Remaining counts readable at any time
// - On/off bits; status shows direction enables
// - Pointer steps 1, 2 or 4 bytes
// - Rewritten pointer used from next item
// - Items decrement current; next counter untouched
// - Both counters zero: stop, set end
// - Next nonzero: reload current, zero next
// - Receive end flag when current reaches zero
// - Receive full only when both zero
// - Transmit end flag when current reaches zero
// - Transmit empty only when both zero
// - Receive ready: read holding, write memory
// - Transmit ready: fetch memory, write holding
// - Peripheral clock needed for transfers, access
// - Half duplex uses transmit or receive sets
// - Nonzero receive count write clears end
// - Nonzero transmit count write clears flags
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module pdc_channel
	import pdc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// AXI4-Lite slave
	input  wire logic [5:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [5:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Serial peripheral side
	input  wire logic             periphClkOn,
	input  wire logic             rxReady,
	input  wire logic             txReady,
	input  wire logic [31:0]      rxHoldData,
	output logic [31:0]           txHoldData,
	output logic                  txHoldWrite,
	output logic                  rxHoldRead,
	output logic                  rxSegmentDone,
	output logic                  txSegmentDone,
	output logic                  rxBuffersFull,
	output logic                  txBuffersEmpty,
	// Bus matrix side
	output pdc_pkg::pdc_mreq_s    memReq,
	input  wire logic             memGrant,
	input  wire logic             memDone,
	input  wire logic [31:0]      memRdata
);
	import pdc_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef enum { ST_IDLE, ST_RX_REQ, ST_RX_MEM, ST_TX_REQ,
		ST_TX_MEM, ST_TX_HOLD } pdc_seq_e;

	typedef struct packed
	{
		logic        awSeen;    // Write address held
		logic [5:0]  awAddr;
		logic        wSeen;     // Write data held
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic        rxOn;      // Receive direction enabled
		logic        txOn;      // Transmit direction enabled
		logic        halfDup;   // Single bidirectional channel
		logic        dirTx;     // Half duplex operating direction
		pdc_size_e   size;
		logic        rxPend;    // Receive ready latched
		logic        txPend;    // Transmit ready latched
		logic [31:0] buffer;    // Internal data holding
		logic        txWr;
		logic        rxRd;
		pdc_mreq_s   mreq;
	} pdc_top_s;

	pdc_top_s    st_q;           // Registered state
	pdc_top_s    st_d;           // Next state
	pdc_seq_e    seq_q;          // Sequencer state
	pdc_seq_e    seq_d;
	pdc_set_s    rxCur;
	pdc_set_s    rxNxt;
	pdc_set_s    txCur;
	pdc_set_s    txNxt;
	logic        rxActive;
	logic        txActive;
	logic        rxEnd;
	logic        txEnd;
	logic        rxFull;
	logic        txEmpty;
	logic        doWrite;        // Both write channels in hand
	logic [31:0] wrMerged;       // Write data after strobes
	logic        rxStep;
	logic        txStep;
	logic        wrRxC;
	logic        wrRxN;
	logic        wrTxC;
	logic        wrTxN;
	logic        selPtr;
	logic        rxEnEff;        // Receive enable seen by datapath
	logic        txEnEff;
	logic [31:0] rdMux;
	logic        rdHit;
	logic        wrHit;

	// Register writes need the peripheral clock running
	assign doWrite = st_q.awSeen && st_q.wSeen && !st_q.bValid;
	assign wrMerged = {st_q.wStrb[3] ? st_q.wData[31:24] : 8'h00,
		st_q.wStrb[2] ? st_q.wData[23:16] : 8'h00,
		st_q.wStrb[1] ? st_q.wData[15:8] : 8'h00,
		st_q.wStrb[0] ? st_q.wData[7:0] : 8'h00};
	assign selPtr = !st_q.awAddr[2];
	// Half duplex locks programming to the operating direction
	assign wrRxC = doWrite && periphClkOn && !(st_q.halfDup && st_q.dirTx)
		&& (st_q.awAddr == PDC_RX_PTR_OFS || st_q.awAddr == PDC_RX_CNT_OFS);
	assign wrRxN = doWrite && periphClkOn && !(st_q.halfDup && st_q.dirTx)
		&& (st_q.awAddr == PDC_RX_NPTR_OFS
		|| st_q.awAddr == PDC_RX_NCNT_OFS);
	assign wrTxC = doWrite && periphClkOn && !(st_q.halfDup && !st_q.dirTx)
		&& (st_q.awAddr == PDC_TX_PTR_OFS || st_q.awAddr == PDC_TX_CNT_OFS);
	assign wrTxN = doWrite && periphClkOn && !(st_q.halfDup && !st_q.dirTx)
		&& (st_q.awAddr == PDC_TX_NPTR_OFS
		|| st_q.awAddr == PDC_TX_NCNT_OFS);
	// Half duplex serves only its current direction
	assign rxEnEff = st_q.rxOn && periphClkOn
		&& !(st_q.halfDup && st_q.dirTx);
	assign txEnEff = st_q.txOn && periphClkOn
		&& !(st_q.halfDup && !st_q.dirTx);

	// ==========================================================
	// Direction datapaths
	// ==========================================================
	// Receive sets
	pdc_dir u_rx
	(
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.enable  (rxEnEff),
		.wrCur   (wrRxC),
		.wrNext  (wrRxN),
		.selPtr  (selPtr),
		.wdata   (wrMerged),
		.step    (rxStep),
		.size    (st_q.size),
		.curSet  (rxCur),
		.nextSet (rxNxt),
		.active  (rxActive),
		.endFlag (rxEnd),
		.bufFlag (rxFull)
	);

	// Transmit sets
	pdc_dir u_tx
	(
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.enable  (txEnEff),
		.wrCur   (wrTxC),
		.wrNext  (wrTxN),
		.selPtr  (selPtr),
		.wdata   (wrMerged),
		.step    (txStep),
		.size    (st_q.size),
		.curSet  (txCur),
		.nextSet (txNxt),
		.active  (txActive),
		.endFlag (txEnd),
		.bufFlag (txEmpty)
	);

	// ==========================================================
	// Read multiplexer
	// ==========================================================
	// Counters read live, even mid-transfer
	always_comb
	begin
		rdHit = 1'b1;
		rdMux = PDC_ZERO32;
		case (s_axi_araddr)
			PDC_RX_PTR_OFS:  rdMux = rxCur.ptr;
			PDC_RX_CNT_OFS:  rdMux = {PDC_ZERO16, rxCur.cnt};
			PDC_TX_PTR_OFS:  rdMux = txCur.ptr;
			PDC_TX_CNT_OFS:  rdMux = {PDC_ZERO16, txCur.cnt};
			PDC_RX_NPTR_OFS: rdMux = rxNxt.ptr;
			PDC_RX_NCNT_OFS: rdMux = {PDC_ZERO16, rxNxt.cnt};
			PDC_TX_NPTR_OFS: rdMux = txNxt.ptr;
			PDC_TX_NCNT_OFS: rdMux = {PDC_ZERO16, txNxt.cnt};
			PDC_CTRL_OFS:    rdMux = PDC_ZERO32; // Write-only
			PDC_STAT_OFS:
			begin
				rdMux[PDC_STAT_RX_TRIGGER_ENABLE_BIT] = st_q.rxOn;
				rdMux[PDC_STAT_TX_TRIGGER_ENABLE_BIT] = st_q.txOn;
			end
			PDC_FLAG_OFS:
			begin
				rdMux[PDC_FLAG_RECEIVE_SEGMENT_DONE_BIT] = rxEnd;
				rdMux[PDC_FLAG_TRANSMIT_SEGMENT_DONE_BIT] = txEnd;
				rdMux[PDC_FLAG_RXBF_BIT]  = rxFull;
				rdMux[PDC_FLAG_TXBE_BIT]  = txEmpty;
			end
			PDC_MODE_OFS:
			begin
				rdMux[PDC_MODE_HALF_BIT]  = st_q.halfDup;
				rdMux[PDC_MODE_DIRTX_BIT] = st_q.dirTx;
				rdMux[PDC_MODE_SIZE_LSB +: 2] = st_q.size;
			end
			default:         rdHit = 1'b0;
		endcase
		// Without the peripheral clock registers cannot be reached
		if (!periphClkOn)
			rdHit = 1'b0;
	end

	assign wrHit = periphClkOn && (st_q.awAddr <= PDC_MODE_OFS)
		&& (st_q.awAddr[1:0] == 2'h0);

	// ==========================================================
	// Next-state logic: bus slave, control and sequencer
	// ==========================================================
	always_comb
	begin
		st_d = st_q;
		seq_d = seq_q;
		rxStep = 1'b0;
		txStep = 1'b0;
		st_d.txWr = 1'b0;
		st_d.rxRd = 1'b0;
		// Write channels taken in either order
		if (s_axi_awvalid && !st_q.awSeen)
		begin
			st_d.awSeen = 1'b1;
			st_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.wSeen)
		begin
			st_d.wSeen = 1'b1;
			st_d.wData = s_axi_wdata;
			st_d.wStrb = s_axi_wstrb;
		end
		if (doWrite)
		begin
			st_d.bValid = 1'b1;
			st_d.bResp = wrHit ? PDC_RESP_OKAY : PDC_RESP_SLVERR;
			if (wrHit && st_q.awAddr == PDC_CTRL_OFS)
			begin
				// Off wins over on when both are written
				if (wrMerged[PDC_CTRL_RXON_BIT])
					st_d.rxOn = 1'b1;
				if (wrMerged[PDC_CTRL_RXOFF_BIT])
					st_d.rxOn = 1'b0;
				if (wrMerged[PDC_CTRL_TXON_BIT])
					st_d.txOn = 1'b1;
				if (wrMerged[PDC_CTRL_TXOFF_BIT])
					st_d.txOn = 1'b0;
			end
			if (wrHit && st_q.awAddr == PDC_MODE_OFS)
			begin
				st_d.halfDup = wrMerged[PDC_MODE_HALF_BIT];
				st_d.dirTx = wrMerged[PDC_MODE_DIRTX_BIT];
				st_d.size = pdc_size_e'(wrMerged[PDC_MODE_SIZE_LSB +: 2]);
			end
		end
		if (st_q.bValid && s_axi_bready)
		begin
			st_d.bValid = 1'b0;
			st_d.awSeen = 1'b0;
			st_d.wSeen = 1'b0;
		end
		// Read channel
		if (s_axi_arvalid && !st_q.rValid)
		begin
			st_d.rValid = 1'b1;
			st_d.rData = rdHit ? rdMux : PDC_ZERO32;
			st_d.rResp = rdHit ? PDC_RESP_OKAY : PDC_RESP_SLVERR;
		end
		else if (st_q.rValid && s_axi_rready)
			st_d.rValid = 1'b0;
		// Ready strobes count only while the direction runs
		if (rxReady && rxActive)
			st_d.rxPend = 1'b1;
		if (txReady && txActive)
			st_d.txPend = 1'b1;
		// Sequencer: receive first, then transmit
		case (seq_q)
			ST_IDLE:
			begin
				if (st_q.rxPend && rxActive)
				begin
					seq_d = ST_RX_REQ;
					st_d.buffer = rxHoldData;
					st_d.rxRd = 1'b1;
					st_d.rxPend = rxReady && rxActive;
				end
				else if (st_q.txPend && txActive)
				begin
					seq_d = ST_TX_REQ;
					st_d.txPend = txReady && txActive;
				end
				else
				begin
					st_d.rxPend = st_d.rxPend && rxActive;
					st_d.txPend = st_d.txPend && txActive;
				end
			end
			ST_RX_REQ:
			begin
				st_d.mreq = '{1'b1, 1'b1, rxCur.ptr, st_q.buffer,
					st_q.size};
				if (memGrant && st_q.mreq.req)
					seq_d = ST_RX_MEM;
			end
			ST_RX_MEM:
			begin
				if (memDone)
				begin
					st_d.mreq.req = 1'b0;
					rxStep = 1'b1;
					seq_d = ST_IDLE;
				end
			end
			ST_TX_REQ:
			begin
				st_d.mreq = '{1'b1, 1'b0, txCur.ptr, PDC_ZERO32,
					st_q.size};
				if (memGrant && st_q.mreq.req)
					seq_d = ST_TX_MEM;
			end
			ST_TX_MEM:
			begin
				if (memDone)
				begin
					st_d.mreq.req = 1'b0;
					st_d.buffer = memRdata;
					seq_d = ST_TX_HOLD;
				end
			end
			ST_TX_HOLD:
			begin
				st_d.txWr = 1'b1;
				txStep = 1'b1;
				seq_d = ST_IDLE;
			end
			default: seq_d = ST_IDLE;
		endcase
	end

	// ==========================================================
	// State registers
	// ==========================================================
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
			seq_q <= ST_IDLE;
		end
		else
		begin
			st_q <= st_d;
			seq_q <= seq_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign s_axi_awready = !st_q.awSeen;
	assign s_axi_wready  = !st_q.wSeen;
	assign s_axi_bvalid  = st_q.bValid;
	assign s_axi_bresp   = st_q.bResp;
	assign s_axi_arready = !st_q.rValid;
	assign s_axi_rvalid  = st_q.rValid;
	assign s_axi_rdata   = st_q.rData;
	assign s_axi_rresp   = st_q.rResp;
	assign txHoldData    = st_q.buffer;
	assign txHoldWrite   = st_q.txWr;
	assign rxHoldRead    = st_q.rxRd;
	// Flags go to the peripheral, which raises its own interrupt
	assign rxSegmentDone  = rxEnd;
	assign txSegmentDone  = txEnd;
	assign rxBuffersFull  = rxFull;
	assign txBuffersEmpty = txEmpty;
	assign memReq         = st_q.mreq;

endmodule

// ===== sim/pdc_channel_sva.sv
// Checker of port timing for the peripheral DMA channel
module pdc_channel_sva
	import pdc_pkg::*;
(
	input wire logic      mclk,
	input wire logic      sys_rst,
	input wire logic      s_axi_awready,
	input wire logic      s_axi_bvalid,
	input wire logic      s_axi_bready,
	input wire logic      s_axi_arvalid,
	input wire logic      s_axi_arready,
	input wire logic      s_axi_rvalid,
	input wire logic      s_axi_rready,
	input wire logic      periphClkOn,
	input wire logic      rxHoldRead,
	input wire logic      txHoldWrite,
	input wire logic      rxSegmentDone,
	input wire logic      txSegmentDone,
	input wire logic      rxBuffersFull,
	input wire logic      txBuffersEmpty,
	input wire pdc_mreq_s memReq,
	input wire logic      memDone
);
	import pdc_pkg::*;
	// ==========================================================
	// Clocking and steps of one item
	// ==========================================================
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Holding register read, then memory write
	sequence rxRead; rxHoldRead; endsequence
	sequence memWrite; memReq.req && memReq.wr; endsequence
	// Memory fetch completes; holding write follows two cycles on
	sequence txFetch; memReq.req && !memReq.wr && memDone; endsequence
	// ==========================================================
	// Assertions
	// ==========================================================
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	aw_block_a: assert property (
		s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
	rx_order_a: assert property (rxRead |=> memWrite)
		else $error("memory write does not follow holding read");
	req_hold_a: assert property (
		memReq.req && !memDone |=> memReq.req && $stable(memReq.addr))
		else $error("memory request changed before done");
	tx_order_a: assert property (txFetch |-> ##2 txHoldWrite)
		else $error("holding write missing after fetch");
	clk_off_a: assert property (
		!periphClkOn |-> !rxHoldRead && !txHoldWrite)
		else $error("transfer with peripheral clock off");
	rx_full_a: assert property (rxBuffersFull |-> rxSegmentDone)
		else $error("receive full without receive end");
	tx_empty_a: assert property (txBuffersEmpty |-> txSegmentDone)
		else $error("transmit empty without transmit end");
endmodule

bind pdc_channel pdc_channel_sva u_pdc_channel_sva (.*);

// ===== sim/pdc_mem_model.sv
// Behavioural bus matrix and memory answering the channel
module pdc_mem_model
	import pdc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire pdc_mreq_s  memReq,
	input wire logic [3:0] lat,
	output logic           memGrant,
	output logic           memDone,
	output logic [31:0]    memRdata,
	output logic [15:0]    wrCnt,
	output logic [31:0]    lastAddr,
	output logic [31:0]    lastData
);
	import pdc_pkg::*;
	logic [3:0] waitQ; // Cycles spent on the current request
	// ==========================================================
	// Grant at once, finish lat+1 cycles after the grant; lat sets the pace
	// ==========================================================
	always_ff @(posedge mclk)
	begin
		memDone <= 1'h0;
		// Idle data keeps toggling so stale values never match
		memRdata <= ~memRdata;
		if (sys_rst || !memReq.req || memDone)
		begin
			waitQ <= 4'h0;
			memGrant <= 1'h0;
			if (sys_rst)
				wrCnt <= 16'h0;
		end
		else
		begin
			waitQ <= waitQ + 4'h1;
			memGrant <= 1'h1;
			if (waitQ == lat + 4'h1)
			begin
				memDone <= 1'h1;
				// Fetch data derived from the address
				memRdata <= memReq.addr ^ 32'ha5a5_0000;
				// Record stored item
				if (memReq.wr)
				begin
					wrCnt <= wrCnt + 16'h1;
					lastAddr <= memReq.addr;
					lastData <= memReq.wdata;
				end
			end
		end
	end
endmodule

// ===== sim/tb_peripheral_dma_channel.sv
// Self-checking bench for the peripheral DMA channel
module tb_peripheral_dma_channel;
	timeunit 1ns;
	timeprecision 1ps;
	import pdc_pkg::*;
	logic mclk = 1'h0, sys_rst = 1'h1, periphClkOn = 1'h1;
	logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic rxReady = '0, txReady = '0;
	logic [31:0] s_axi_wdata = '0, rxHoldData = '0;
	logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, txHoldWrite, rxHoldRead, memGrant, memDone;
	logic rxSegmentDone, txSegmentDone, rxBuffersFull, txBuffersEmpty;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, txHoldData, memRdata, lastAddr, lastData;
	logic [31:0] d;
	logic [15:0] wrCnt;
	pdc_mreq_s memReq;
	int num_errors = 0, samples_checked = 0;
	localparam logic [1:0] OK = PDC_RESP_OKAY;
	pdc_channel u_pdc_channel (.*);
	pdc_mem_model u_pdc_mem_model (.*);
	initial forever #10 mclk = ~mclk;
	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Write: readiness sampled mid-cycle equals the next edge
	task automatic axw(input logic [5:0] a, input logic [31:0] v,
		input logic [1:0] e);
		logic ta, tw, hs;
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do
		begin
			@(negedge mclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			hs = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			n++;
		end
		while (!hs && n < 50);
		s_axi_bready <= 1'h0;
		chk(hs, 1'h1);
		chk(r, e);
		// Let an edge pass so the next call never re-drives in this step
		@(posedge mclk);
	endtask
	task automatic axr(input logic [5:0] a);
		logic ta, hs;
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do
		begin
			@(negedge mclk);
			ta = s_axi_arvalid & s_axi_arready;
			hs = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			if (ta) s_axi_arvalid <= 1'h0;
			n++;
		end
		while (!hs && n < 50);
		s_axi_rready <= 1'h0;
		chk(hs, 1'h1);
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		axr(a);
		chk(d, e);
	endtask
	// Receive item: strobe, then wait for the stored word
	task automatic rxItem(input logic [31:0] v);
		logic [15:0] k;
		int n;
		k = wrCnt;
		rxHoldData <= v;
		rxReady <= 1'h1;
		@(posedge mclk);
		rxReady <= 1'h0;
		n = 0;
		while (wrCnt == k && n < 60)
		begin
			@(posedge mclk);
			n++;
		end
		// Counters and flags step on the edge after the store
		@(posedge mclk);
	endtask
	// Transmit item: strobe, then catch the holding write pulse
	task automatic txItem(input logic [31:0] a);
		int n;
		txReady <= 1'h1;
		@(posedge mclk);
		txReady <= 1'h0;
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (txHoldWrite !== 1'h1 && n < 60);
		chk(txHoldWrite, 1'h1);
		chk(txHoldData, a ^ 32'ha5a5_0000);
		@(posedge mclk);
	endtask
	// ==========================================================
	// Watchdog and main sequence
	// ==========================================================
	initial
	begin
		#200us;
		num_errors++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'h0;
		@(posedge mclk);
		for (int i = 0; i < 12; i++)
			rdchk(6'(i * 4), 32'h0);
		axr(6'h30);
		chk(r, PDC_RESP_SLVERR);
		// Receive with pointer rewrite and reload
		axw(PDC_MODE_OFS, 32'h20, OK);
		axw(PDC_RX_PTR_OFS, 32'h100, OK);
		axw(PDC_RX_CNT_OFS, 32'h2, OK);
		axw(PDC_RX_NPTR_OFS, 32'h200, OK);
		axw(PDC_RX_NCNT_OFS, 32'h1, OK);
		axw(PDC_CTRL_OFS, 32'h1, OK);
		rdchk(PDC_STAT_OFS, 32'h1);
		rxItem(32'hc0de_0001);
		chk(lastAddr, 32'h100);
		chk(lastData, 32'hc0de_0001);
		rdchk(PDC_RX_CNT_OFS, 32'h1);
		rdchk(PDC_RX_NCNT_OFS, 32'h1);
		axw(PDC_RX_PTR_OFS, 32'h180, OK);
		rxItem(32'hc0de_0002);
		chk(lastAddr, 32'h180);
		chk(rxBuffersFull, 32'h0);
		rdchk(PDC_RX_PTR_OFS, 32'h200);
		rdchk(PDC_RX_NCNT_OFS, 32'h0);
		rxItem(32'hc0de_0003);
		chk(lastAddr, 32'h200);
		chk(rxSegmentDone, 32'h1);
		chk(rxBuffersFull, 32'h1);
		rxItem(32'hc0de_0004);
		chk(wrCnt, 32'h3);
		axw(PDC_RX_NCNT_OFS, 32'h1, OK);
		chk(rxSegmentDone, 32'h0);
		// Disabled direction ignores strobes
		axw(PDC_CTRL_OFS, 32'h2, OK);
		rdchk(PDC_STAT_OFS, 32'h0);
		axw(PDC_RX_CNT_OFS, 32'h3, OK);
		rxItem(32'hc0de_0005);
		chk(wrCnt, 32'h3);
		rdchk(PDC_RX_CNT_OFS, 32'h3);
		// Half duplex in transmit direction locks receive sets
		axw(PDC_MODE_OFS, 32'h23, OK);
		axw(PDC_RX_CNT_OFS, 32'h5, OK);
		rdchk(PDC_RX_CNT_OFS, 32'h3);
		// Transmit for each item size against a slow memory
		lat <= 4'h3;
		axw(PDC_CTRL_OFS, 32'h100, OK);
		for (int s = 0; s < 3; s++)
		begin
			axw(PDC_MODE_OFS, 32'(s) << 4, OK);
			axw(PDC_TX_PTR_OFS, 32'h40, OK);
			axw(PDC_TX_CNT_OFS, 32'h2, OK);
			chk(txBuffersEmpty, 32'h0);
			chk(txSegmentDone, 32'h0);
			txItem(32'h40);
			txItem(32'h40 + (32'h1 << s));
			rdchk(PDC_TX_PTR_OFS, 32'h40 + (32'h2 << s));
			chk(txSegmentDone, 32'h1);
			chk(txBuffersEmpty, 32'h1);
		end
		// Peripheral clock off refuses access
		periphClkOn <= 1'h0;
		axw(PDC_TX_CNT_OFS, 32'h1, PDC_RESP_SLVERR);
		axr(PDC_TX_CNT_OFS);
		chk(r, PDC_RESP_SLVERR);
		chk(d, 32'h0);
		periphClkOn <= 1'h1;
		rdchk(PDC_TX_CNT_OFS, 32'h0);
		close_out();
	end
endmodule
